// ==== verilog/ivec_ctrl.sv ====
// Control register for vector placement, brown-out-off sequence and pull-up disable,
// plus external and pin-change interrupt detection.
// Assumes the core presents single-cycle I/O writes and reads and an instruction-done strobe.
`include "ivec_defs.svh"
module ivec_ctrl (
    input  wire logic                 clock,          // I/O clock, 250 MHz
    input  wire logic                 arst_n,         // Asynchronous reset, active low
    input  wire logic                 clk_en,         // Freezes all state while low
    input  wire logic [7:0]           addr,           // Data-space or I/O address from the core
    input  wire logic                 io_space,       // High when addr is an I/O address
    input  wire logic                 wr_en,          // Register write strobe
    input  wire logic                 rd_en,          // Register read strobe
    input  wire logic [7:0]           wdata,          // Write data
    input  wire logic                 instr_done,     // Pulse at each instruction end
    input  wire logic                 sleep_exec,     // Pulse when sleep executes
    input  wire logic                 exec_in_boot,   // Core fetches from boot section
    input  wire logic                 app_boot_lock,  // Lock bit, programmed high
    input  wire logic                 boot_side_lock, // Lock bit, programmed high
    input  wire logic [15:0]          boot_reset_addr,// Set by boot size fuse
    input  wire logic [1:0]           ext_pin,        // Sense-controlled pins
    input  wire ivec_pkg::ivec_sense_t sense_0,       // Sense mode of channel 0
    input  wire ivec_pkg::ivec_sense_t sense_1,       // Sense mode of channel 1
    input  wire logic [1:0]           ext_flag_clr,   // Flag clears, one per channel
    input  wire logic [23:0]          pin_change_input, // Grouped pin-change inputs
    input  wire logic [7:0]           pin_change_mask_0, // Group 7:0 mask
    input  wire logic [7:0]           pin_change_mask_1, // Group 14:8 mask, bit 7 unused
    input  wire logic [7:0]           pin_change_mask_2, // Group 23:16 mask
    input  wire logic [7:0]           pin_ref,        // Last pin-change levels taken by software
    output logic [7:0]                rdata,          // Read data
    output logic                      irq_block,      // Interrupts blocked
    output logic                      vector_select,  // Vector table in boot section
    output logic [15:0]               vector_base,    // Vector table start address
    output logic                      pullup_disable, // Port pull-ups forced off
    output logic                      brownout_off,   // Brown-out detector off in sleep
    output logic [1:0]                ext_irq_flag,   // Edge flags
    output logic [1:0]                ext_level_req,  // Level requests
    output logic                      pin_change_request_0, // Group 7:0 change
    output logic                      pin_change_request_1, // Group 14:8 change
    output logic                      pin_change_request_2  // Group 23:16 change
);
    import ivec_pkg::*;

    localparam logic [7:0] CTRL_RST = `IVEC_CTRL_RESET; // Reset image of the register.

    // Address decode for either address space.
    wire hit_w = io_space ? (addr == `IVEC_IO_ADDR) : (addr == `IVEC_DATA_ADDR); // (R11)
    wire wr_w  = wr_en & hit_w;
    wire rd_w  = rd_en & hit_w;

    logic       sel_q;
    logic       sel_d;
    logic       ce_q;
    logic       ce_d;
    logic [2:0] ce_cnt_q;
    logic [2:0] ce_cnt_d;
    logic       blk_q;
    logic       blk_d;
    logic       post_sel_q;
    logic       post_sel_d;
    logic       pud_q;
    logic       brownout_off_unlock_q;
    logic       brownout_off_in_sleep_q;
    logic       brownout_off_in_sleep_d;
    ivec_bod_state_t bod_st_q;
    ivec_bod_state_t bod_st_d;
    logic [2:0] bod_cnt_q;
    logic [2:0] bod_cnt_d;
    logic       bod_off_q;
    logic [7:0] rdata_q;
    logic [15:0] base_q;

    // Change window: opened by writing the change enable, closed after four cycles.
    wire ce_wr_w   = wr_w & wdata[`IVEC_BIT_CE];
    wire sel_wr_w  = wr_w & ~wdata[`IVEC_BIT_CE] & ce_q; // (R2)
    wire ce_exp_w  = ce_q & (ce_cnt_q == (`IVEC_WINDOW_CYC - 3'h1));

    // Select moves only through the open window; stray writes are ignored.
    assign sel_d = sel_wr_w ? wdata[`IVEC_BIT_SEL] : sel_q; // (R2) (R24)
    // Change enable drops on the select write or at expiry.
    assign ce_d  = ce_wr_w ? 1'b1 : ((sel_wr_w | ce_exp_w) ? 1'b0 : ce_q); // (R5)
    assign ce_cnt_d = ce_wr_w ? 3'h0 : (ce_q ? ce_cnt_q + 3'h1 : 3'h0);

    // Block holds through the instruction after the select write, or the window.
    assign post_sel_d = sel_wr_w ? 1'b1 : (instr_done ? 1'b0 : post_sel_q);
    assign blk_d = ce_wr_w | ce_d | post_sel_d; // (R3)

    // Interrupts are gated here only; the status word's global enable is never written.
    wire lock_blk_w = (sel_q & app_boot_lock & ~exec_in_boot) |
                      (~sel_q & boot_side_lock & exec_in_boot); // (R6) (R4)

    // Brown-out-off sequence: unlock, then confirm, delay three, hold three.
    wire bod_unlock_w  = wr_w & wdata[`IVEC_BIT_BROWNOUT_OFF_IN_SLEEP] & wdata[`IVEC_BIT_BROWNOUT_OFF_UNLOCK];
    wire bod_confirm_w = wr_w & wdata[`IVEC_BIT_BROWNOUT_OFF_IN_SLEEP] & ~wdata[`IVEC_BIT_BROWNOUT_OFF_UNLOCK];
    wire bod_cnt_end_w = (bod_cnt_q == 3'h1);

    always_comb begin
        bod_st_d  = bod_st_q;
        bod_cnt_d = (bod_cnt_q != 3'h0) ? bod_cnt_q - 3'h1 : 3'h0;
        unique case (bod_st_q)
            IVEC_BOD_IDLE: begin
                if (bod_unlock_w) begin
                    bod_st_d  = IVEC_BOD_UNLOCK;
                    bod_cnt_d = `IVEC_WINDOW_CYC;
                end
            end
            IVEC_BOD_UNLOCK: begin
                if (bod_confirm_w) begin // (R7)
                    bod_st_d  = IVEC_BOD_WAIT;
                    bod_cnt_d = `IVEC_BOD_DELAY_CYC;
                end else if (bod_cnt_end_w) begin
                    bod_st_d = IVEC_BOD_IDLE;
                end
            end
            IVEC_BOD_WAIT: begin
                if (bod_cnt_end_w) begin // (R8)
                    bod_st_d  = IVEC_BOD_ACTIVE;
                    bod_cnt_d = `IVEC_BOD_HOLD_CYC;
                end
            end
            IVEC_BOD_ACTIVE: begin
                if (bod_cnt_end_w) begin // (R8)
                    bod_st_d = IVEC_BOD_IDLE;
                end
            end
        endcase
    end
    assign brownout_off_in_sleep_d = (bod_st_d == IVEC_BOD_WAIT) | (bod_st_d == IVEC_BOD_ACTIVE);

    // Control register state.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sel_q      <= CTRL_RST[`IVEC_BIT_SEL];
            ce_q       <= 1'b0;
            ce_cnt_q   <= 3'h0;
            post_sel_q <= 1'b0;
            blk_q      <= 1'b0;
            pud_q      <= 1'b0;
            brownout_off_unlock_q    <= 1'b0;
            brownout_off_in_sleep_q     <= 1'b0;
            bod_st_q   <= IVEC_BOD_IDLE;
            bod_cnt_q  <= 3'h0;
        end else if (clk_en) begin
            sel_q      <= sel_d;
            ce_q       <= ce_d;
            ce_cnt_q   <= ce_cnt_d;
            post_sel_q <= post_sel_d;
            blk_q      <= blk_d | lock_blk_w; // (R3) (R6)
            pud_q      <= wr_w ? wdata[`IVEC_BIT_PUD] : pud_q; // (R10)
            brownout_off_unlock_q    <= bod_st_d == IVEC_BOD_UNLOCK;
            brownout_off_in_sleep_q     <= brownout_off_in_sleep_d;
            bod_st_q   <= bod_st_d;
            bod_cnt_q  <= bod_cnt_d;
        end
    end

    // Detector turns off only when sleep lands inside the active span.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bod_off_q <= 1'b0;
        end else if (clk_en) begin
            bod_off_q <= sleep_exec ? (bod_st_q == IVEC_BOD_ACTIVE) : bod_off_q; // (R9)
        end
    end

    // Read data and derived outputs, all registered.
    wire [7:0] ctrl_view_w = {1'b0, brownout_off_in_sleep_q, brownout_off_unlock_q, pud_q, 2'b00, sel_q, ce_q};
    wire [15:0] base_w = sel_d ? boot_reset_addr + `IVEC_BOOT_OFFSET
                               : `IVEC_APP_BASE; // (R1) (R22)
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q    <= 8'h00;
            base_q     <= `IVEC_APP_BASE;
        end else if (clk_en) begin
            rdata_q    <= rd_w ? ctrl_view_w : 8'h00;
            base_q     <= base_w;
        end
    end

    // Both block causes share one flop, so the core sees a glitch-free gate.
    assign irq_block      = blk_q;
    assign rdata          = rdata_q;
    assign vector_select  = sel_q;
    assign vector_base    = base_q;
    assign pullup_disable = pud_q;
    assign brownout_off   = bod_off_q;

    // Two sense channels share one module.
    ivec_ext_sense u_ext0 (
        .clock     (clock),
        .arst_n    (arst_n),
        .clk_en    (clk_en),
        .pin       (ext_pin[0]),
        .sense     (sense_0),
        .flag_clr  (ext_flag_clr[0]),
        .flag      (ext_irq_flag[0]),
        .level_req (ext_level_req[0])
    );
    ivec_ext_sense u_ext1 (
        .clock     (clock),
        .arst_n    (arst_n),
        .clk_en    (clk_en),
        .pin       (ext_pin[1]),
        .sense     (sense_1),
        .flag_clr  (ext_flag_clr[1]),
        .flag      (ext_irq_flag[1]),
        .level_req (ext_level_req[1])
    );

    // Pin change is a clockless compare against the software reference levels, so it can
    // wake the part with the clock halted; the trade is no glitch filtering.
    assign pin_change_request_0 = |((pin_change_input[7:0] ^ pin_ref) &
                                    pin_change_mask_0); // (R13) (R14) (R15) (R12)
    assign pin_change_request_1 = |((pin_change_input[14:8] ^ pin_ref[6:0]) &
                                    pin_change_mask_1[6:0]); // (R13) (R14)
    assign pin_change_request_2 = |((pin_change_input[23:16] ^ pin_ref) &
                                    pin_change_mask_2); // (R13) (R14)
endmodule : ivec_ctrl

// ==== verilog/ivec_defs.svh ====
// Offsets, field positions, reset values and timing counts of the vector and pin-interrupt
// control logic. Definitions only; included by the control, sense and checker modules and the bench.
//
// Operation
// (R1) Vector-select clear puts vectors at flash start; set puts them in boot section.
// (R2) Vector-select changes only via change-enable write, then select write within four cycles.
// (R3) Interrupts blocked from change-enable write until after following instruction, or four cycles.
// (R4) Automatic blocking leaves the global interrupt enable bit untouched.
// (R5) Change-enable clears four cycles after written or when vector-select is written.
// (R6) Boot-lock bits block interrupts while executing from the section without vectors.
// (R7) Brown-out-off bit armed by writing both bits one, then bit alone within four cycles.
// (R8) Brown-out-off bit active three cycles after set, cleared after three more.
// (R9) Brown-out detector turns off only on sleep while brown-out-off bit is active.
// (R10) Pull-up disable bit one forces every port pull-up off.
// (R11) Control register at data offset 0x55, I/O offset 0x35, difference 0x20.
// (R12) Pin interrupts trigger from pin activity even when pins drive outputs.
// (R13) Pin-change requests 2, 1, 0 from groups 23:16, 14:8, 7:0.
// (R14) Per-group mask registers select contributing pins.
// (R15) Pin-change detection works without the I/O clock.
// (R16) Low-level sense keeps requesting while the pin stays low.
// (R17) Edge sense works only while the I/O clock runs.
// (R18) Low-level detection works without the I/O clock.
// (R19) Wake level must last through start-up, else wake without interrupt.
// (R20) Sense code 00 low, 01 any change, 10 falling, 11 rising.
// (R21) Edge flag set by trigger, cleared by handler or write one, zero in level mode.
// (R22) Vector table base 0x002, or boot reset address plus 0x0002.
// (R23) Edge detection compares current with previous sample each I/O clock.
// (R24) Vector-select write outside an open window leaves it unchanged.
`ifndef IVEC_DEFS_SVH
`define IVEC_DEFS_SVH

`define IVEC_DATA_ADDR      8'h55
`define IVEC_IO_ADDR        8'h35
`define IVEC_IO_DELTA       8'h20
`define IVEC_CTRL_RESET     8'h00
`define IVEC_BIT_BROWNOUT_OFF_IN_SLEEP       6
`define IVEC_BIT_BROWNOUT_OFF_UNLOCK      5
`define IVEC_BIT_PUD        4
`define IVEC_BIT_SEL        1
`define IVEC_BIT_CE         0
`define IVEC_WINDOW_CYC     3'h4
`define IVEC_BOD_DELAY_CYC  3'h3
`define IVEC_BOD_HOLD_CYC   3'h3
`define IVEC_APP_BASE       16'h0002
`define IVEC_BOOT_OFFSET    16'h0002
`define IVEC_SENSE_LOW      2'h0
`define IVEC_SENSE_ANY      2'h1
`define IVEC_SENSE_FALL     2'h2
`define IVEC_SENSE_RISE     2'h3

`endif

// ==== verilog/ivec_pkg.sv ====
// Types shared by the vector and pin-interrupt control logic.
// Assumes the defines header is compiled alongside it.
package ivec_pkg;
    typedef enum logic [1:0] {
        IVEC_SENSE_LOW_E  = 2'h0,
        IVEC_SENSE_ANY_E  = 2'h1,
        IVEC_SENSE_FALL_E = 2'h2,
        IVEC_SENSE_RISE_E = 2'h3
    } ivec_sense_t;

    // Brown-out-off sequence: Gray coded along idle, unlocked, waiting, active.
    typedef enum logic [1:0] {
        IVEC_BOD_IDLE   = 2'b00,
        IVEC_BOD_UNLOCK = 2'b01,
        IVEC_BOD_WAIT   = 2'b11,
        IVEC_BOD_ACTIVE = 2'b10
    } ivec_bod_state_t;
endpackage : ivec_pkg

// ==== verilog/ivec_ext_sense.sv ====
// One sense-controlled external interrupt channel: edge flag and level request.
// Assumes the pin is already synchronous to clock; the level path is combinational.
`include "ivec_defs.svh"
module ivec_ext_sense (
    input  wire logic                 clock,     // I/O clock
    input  wire logic                 arst_n,    // Asynchronous reset, active low
    input  wire logic                 clk_en,    // Freezes state while low
    input  wire logic                 pin,       // Pin level, read even when driven as output
    input  wire ivec_pkg::ivec_sense_t sense,    // Sense mode
    input  wire logic                 flag_clr,  // Write-one or handler clear
    output logic                      flag,      // Registered edge flag
    output logic                      level_req  // Asynchronous low-level request
);
    import ivec_pkg::*;

    logic pin_prev_q;
    logic prev_ok_q;
    logic flag_q;
    logic flag_d;
    wire  rise_w = pin & ~pin_prev_q;
    wire  fall_w = ~pin & pin_prev_q;
    wire  is_level_w = (sense == IVEC_SENSE_LOW_E);
    wire  hit_w = (sense == IVEC_SENSE_ANY_E  & (rise_w | fall_w)) |
                  (sense == IVEC_SENSE_FALL_E & fall_w) |
                  (sense == IVEC_SENSE_RISE_E & rise_w); // (R20) (R23)

    // A trigger in the clearing cycle wins, so no edge is lost; level mode holds zero.
    // No edge counts until one real sample is held, so reset cannot fake a transition.
    assign flag_d = is_level_w ? 1'b0 : ((hit_w & prev_ok_q) | (flag_q & ~flag_clr)); // (R21)
    // Level request needs no clock so it can wake the part from deep sleep.
    assign level_req = is_level_w & ~pin; // (R16) (R18) (R12) (R19)
    assign flag = flag_q;

    // Edges are only seen while the clock runs.
    always_ff @(posedge clock or negedge arst_n) begin // (R17)
        if (!arst_n) begin
            pin_prev_q <= 1'b0;
            prev_ok_q  <= 1'b0;
            flag_q     <= 1'b0;
        end else if (clk_en) begin
            pin_prev_q <= pin;
            prev_ok_q  <= 1'b1;
            flag_q     <= flag_d;
        end
    end
endmodule : ivec_ext_sense

// ==== tb/ivec_chk.sv ====
// Concurrent checks on the control register port and the interrupt outputs.
// Bound to the top module from the bench; sees only that module's ports.
`include "ivec_defs.svh"
module ivec_chk
    import ivec_pkg::*;
(
    input wire logic                  clock,                // I/O clock
    input wire logic                  arst_n,               // Reset, active low
    input wire logic                  clk_en,               // State enable
    input wire logic [7:0]            addr,                 // Register address
    input wire logic                  io_space,             // I/O address view
    input wire logic                  wr_en,                // Write strobe
    input wire logic                  rd_en,                // Read strobe
    input wire logic [7:0]            wdata,                // Write data
    input wire logic                  instr_done,           // Instruction end
    input wire logic                  sleep_exec,           // Sleep executed
    input wire logic                  app_boot_lock,        // Lock bit
    input wire logic                  boot_side_lock,       // Lock bit
    input wire logic [15:0]           boot_reset_addr,      // Boot start
    input wire logic [1:0]            ext_pin,              // Sense pins
    input wire ivec_pkg::ivec_sense_t sense_0,              // Channel 0 mode
    input wire logic [7:0]            pin_change_mask_2,    // Group 2 mask
    input wire logic [7:0]            rdata,                // Read data
    input wire logic                  irq_block,            // Interrupts blocked
    input wire logic                  vector_select,        // Table in boot area
    input wire logic [15:0]           vector_base,          // Table start
    input wire logic                  pullup_disable,       // Pull-ups off
    input wire logic                  brownout_off,         // Detector off
    input wire logic [1:0]            ext_irq_flag,         // Edge flags
    input wire logic [1:0]            ext_level_req,        // Level requests
    input wire logic                  pin_change_request_2  // Group 2 request
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // An access counts only when enabled and addressed in either view.
    wire logic hit    = io_space ? (addr == `IVEC_IO_ADDR) : (addr == `IVEC_DATA_ADDR);
    wire logic reg_wr = wr_en && clk_en && hit;
    // Locks are excluded because they may hold the block on their own.
    wire logic quiet  = !wr_en && !instr_done && !app_boot_lock && !boot_side_lock;

    sequence s_ce_wr;
        reg_wr && wdata[0];
    endsequence
    sequence s_quiet5;
        quiet [*5];
    endsequence

    a_ce_block: assert property (s_ce_wr |=> irq_block)
        else $error("unlock write left interrupts open");
    a_ce_expire: assert property (s_ce_wr ##1 s_quiet5 |=> !irq_block)
        else $error("unlock window outlived four cycles");
    a_sel_change: assert property ($changed(vector_select) |-> $past(reg_wr))
        else $error("vector select moved without a write");
    a_base_map: assert property (vector_base == (vector_select ? boot_reset_addr + 16'h0002 : 16'h0002))
        else $error("vector base does not follow select");
    a_pud_follow: assert property (reg_wr |=> pullup_disable == $past(wdata[4]))
        else $error("pull-up disable not taken from write");
    a_unmapped_read: assert property (rd_en && clk_en && !hit |=> rdata == 8'h00)
        else $error("unmapped read returned data");
    a_level_req: assert property (sense_0 == IVEC_SENSE_LOW_E && !ext_pin[0] |-> ext_level_req[0])
        else $error("low level not requested");
    a_flag_level: assert property (clk_en && $past(clk_en) && $past(sense_0) == IVEC_SENSE_LOW_E && sense_0 == IVEC_SENSE_LOW_E |-> !ext_irq_flag[0])
        else $error("edge flag set in level mode");
    a_pc_mask: assert property (pin_change_mask_2 == 8'h00 |-> !pin_change_request_2)
        else $error("masked group raised a request");
    a_bod_cause: assert property ($rose(brownout_off) |-> $past(sleep_exec))
        else $error("detector off without sleep");
endmodule : ivec_chk

// ==== tb/ivec_pin_model.sv ====
// Far side of the interrupt pins: holds each level the bench asks for.
// Assumes requests change at the falling edge; pins follow at the next falling edge.
module ivec_pin_model (
    input  wire logic        clock,   // I/O clock
    input  wire logic [1:0]  ext_lvl, // Wanted sense pin levels
    input  wire logic [23:0] pc_lvl,  // Wanted pin-change levels
    output logic      [1:0]  ext_pin, // Sense pins seen by the device
    output logic      [23:0] pc_pin   // Pin-change inputs seen by the device
);
    // Levels are held until changed, so a wake level lasts as long as needed; the pins
    // carry the same value whether the port drives them as outputs or not.
    always_ff @(negedge clock) begin
        ext_pin <= ext_lvl;
        pc_pin  <= pc_lvl;
    end
endmodule : ivec_pin_model

// ==== tb/irq_vector_and_ext_int_ctrl_tb.sv ====
// Self-checking bench for the vector placement and pin interrupt logic.
// Assumes the design files, the pin model and the checker are compiled first.
`include "ivec_defs.svh"
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module irq_vector_and_ext_int_ctrl_tb
    import ivec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] BOOT_ADDR = 16'h3C00;
    logic        clock = 1'b0, arst_n = 1'b0, clk_en = 1'b1, io_space = 1'b0, wr_en = 1'b0;
    logic        rd_en = 1'b0, instr_done = 1'b0, sleep_exec = 1'b0, exec_in_boot = 1'b0;
    logic        app_boot_lock = 1'b0, irq_block, vector_select, pullup_disable, brownout_off;
    logic        pcr0, pcr1, pcr2, boot_side_lock = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, pin_ref = 8'h00, rdata;
    logic [7:0]  msk0 = 8'h00, msk1 = 8'h00, msk2 = 8'h00, rd;
    logic [1:0]  ext_lvl = 2'h3, ext_pin, flag_clr = 2'h0, ext_irq_flag, ext_level_req;
    logic [23:0] pc_lvl = 24'h0, pc_pin;
    logic [15:0] vector_base;
    ivec_sense_t sense_0 = IVEC_SENSE_LOW_E;
    int          error_cnt = 0, num_checks = 0, seed = 32'hcd34;

    always #2 clock = ~clock;

    ivec_pin_model u_ivec_pin_model (.clock(clock), .ext_lvl(ext_lvl), .pc_lvl(pc_lvl),
        .ext_pin(ext_pin), .pc_pin(pc_pin));
    ivec_ctrl u_ivec_ctrl (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .addr(addr),
        .io_space(io_space), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata),
        .instr_done(instr_done), .sleep_exec(sleep_exec), .exec_in_boot(exec_in_boot),
        .app_boot_lock(app_boot_lock), .boot_side_lock(boot_side_lock),
        .boot_reset_addr(BOOT_ADDR),
        .ext_pin(ext_pin), .sense_0(sense_0), .sense_1(IVEC_SENSE_LOW_E),
        .ext_flag_clr(flag_clr), .pin_change_input(pc_pin), .pin_change_mask_0(msk0),
        .pin_change_mask_1(msk1), .pin_change_mask_2(msk2), .pin_ref(pin_ref),
        .rdata(rdata), .irq_block(irq_block), .vector_select(vector_select),
        .vector_base(vector_base), .pullup_disable(pullup_disable),
        .brownout_off(brownout_off), .ext_irq_flag(ext_irq_flag),
        .ext_level_req(ext_level_req), .pin_change_request_0(pcr0),
        .pin_change_request_1(pcr1), .pin_change_request_2(pcr2));

    // Expected pin-change request: any enabled pin away from its reference level.
    function automatic logic pc_exp(input logic [7:0] lv, input logic [7:0] m,
                                    input logic [7:0] r);
        return |((lv ^ r) & m);
    endfunction : pc_exp
    function automatic logic edge_exp(input ivec_sense_t s, input logic rise);
        return s == IVEC_SENSE_ANY_E || s == (rise ? IVEC_SENSE_RISE_E : IVEC_SENSE_FALL_E);
    endfunction : edge_exp

    // A gap cycle before each access keeps a strobe from being set twice in one step.
    task automatic reg_wr(input logic [7:0] d);
        @(negedge clock);
        io_space = 1'($random(seed));
        addr = io_space ? `IVEC_IO_ADDR : `IVEC_DATA_ADDR;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clock);
        wr_en = 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, input logic io);
        @(negedge clock);
        addr = a;
        io_space = io;
        rd_en = 1'b1;
        @(negedge clock);
        rd_en = 1'b0;
        rd = rdata;
    endtask : reg_rd
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    initial begin
        #(4 * 3000);
        error_cnt++;
        give_verdict();
    end

    initial begin
        repeat (8) @(negedge clock);
        arst_n = 1'b1;
        // Reset value in both address views, then a place that is not mapped.
        reg_rd(`IVEC_DATA_ADDR, 1'b0);
        `CHK("data view", 8'h00, rd)
        reg_rd(`IVEC_IO_ADDR, 1'b1);
        `CHK("io view", 8'h00, rd)
        reg_rd(8'h56, 1'b0);
        `CHK("unmapped", 8'h00, rd)
        reg_wr(8'h02);
        `CHK("select locked", 1'b0, vector_select)
        // Vectors in the application area: boot-side lock blocks while running from boot.
        {boot_side_lock, exec_in_boot} = 2'b11;
        repeat (2) @(negedge clock);
        `CHK("boot lock block", 1'b1, irq_block)
        {boot_side_lock, exec_in_boot} = 2'b00;
        reg_wr(8'h01);
        `CHK("block on unlock", 1'b1, irq_block)
        reg_wr(8'h02);
        `CHK("select moved", 1'b1, vector_select)
        `CHK("boot base", BOOT_ADDR + 16'h0002, vector_base)
        repeat (2) begin
            @(negedge clock) instr_done = 1'b1;
            @(negedge clock) instr_done = 1'b0;
        end
        `CHK("block released", 1'b0, irq_block)
        // Lock on the side without vectors blocks only while running there.
        app_boot_lock = 1'b1;
        repeat (2) @(negedge clock);
        `CHK("lock block", 1'b1, irq_block)
        exec_in_boot = 1'b1;
        repeat (2) @(negedge clock);
        `CHK("lock other side", 1'b0, irq_block)
        {app_boot_lock, exec_in_boot} = 2'b00;
        // A select write after the window has run out is ignored.
        reg_wr(8'h01);
        repeat (6) @(negedge clock);
        reg_wr(8'h00);
        reg_rd(`IVEC_DATA_ADDR, 1'b0);
        `CHK("late select", 8'h02, rd)
        repeat (4) begin
            reg_wr(8'($random(seed)) & 8'h10);
            `CHK("pull-up off", wdata[4], pullup_disable)
        end
        @(negedge clock) sleep_exec = 1'b1;
        @(negedge clock) sleep_exec = 1'b0;
        `CHK("sleep unarmed", 1'b0, brownout_off)
        reg_wr(8'h60);
        reg_wr(8'h40);
        repeat (4) @(negedge clock);
        sleep_exec = 1'b1;
        @(negedge clock) sleep_exec = 1'b0;
        `CHK("sleep armed", 1'b1, brownout_off)
        // Level mode: request while low, flag stays clear.
        ext_lvl = 2'b10;
        repeat (3) @(negedge clock);
        `CHK("level request", 2'b01, ext_level_req)
        `CHK("level flag", 1'b0, ext_irq_flag[0])
        for (int s = 1; s < 4; s++) begin
            sense_0 = ivec_sense_t'(s);
            repeat (3) @(negedge clock);
            for (int k = 0; k < 3; k++) begin
                flag_clr = 2'b01;
                @(negedge clock) flag_clr = 2'b00;
                if (k == 2) `CHK("flag cleared", 1'b0, ext_irq_flag[0])
                if (k == 2) break;
                ext_lvl[0] = ~ext_lvl[0];
                repeat (4) @(negedge clock);
                `CHK("edge flag", edge_exp(sense_0, k == 0), ext_irq_flag[0])
            end
        end
        // Pin change with the state clock held off: detection must not need it.
        clk_en = 1'b0;
        for (int i = 0; i < 20; i++) begin
            pc_lvl = 24'($random(seed));
            {msk2, msk1, msk0} = (i < 2) ? 24'h0 : 24'($random(seed));
            pin_ref = 8'($random(seed));
            @(negedge clock);
            #1;
            `CHK("group 0", pc_exp(pc_pin[7:0], msk0, pin_ref), pcr0)
            `CHK("group 1", pc_exp(pc_pin[15:8], msk1 & 8'h7F, pin_ref), pcr1)
            `CHK("group 2", pc_exp(pc_pin[23:16], msk2, pin_ref), pcr2)
        end
        give_verdict();
    end
endmodule : irq_vector_and_ext_int_ctrl_tb

bind ivec_ctrl ivec_chk u_ivec_chk (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
    .addr(addr), .io_space(io_space), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata),
    .instr_done(instr_done), .sleep_exec(sleep_exec), .app_boot_lock(app_boot_lock),
    .boot_side_lock(boot_side_lock), .boot_reset_addr(boot_reset_addr), .ext_pin(ext_pin),
    .sense_0(sense_0), .pin_change_mask_2(pin_change_mask_2), .rdata(rdata),
    .irq_block(irq_block), .vector_select(vector_select), .vector_base(vector_base),
    .pullup_disable(pullup_disable), .brownout_off(brownout_off),
    .ext_irq_flag(ext_irq_flag), .ext_level_req(ext_level_req),
    .pin_change_request_2(pin_change_request_2));
